// file: core/tsp_defines.svh
// Purpose: Offsets, field positions, reset values and limits of the trap unit
// Assumes: Included by the package and by every design file that needs a figure
// Notes:   Definitions only
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

// Register port geometry
`define TSP_ADDR_W          4
`define TSP_REG_W           16

// Register offsets on the plain register port
`define TSP_OFS_CORE_CTRL   4'h0
`define TSP_OFS_TRAP_STAT   4'h1
`define TSP_OFS_STATUS_WORD 4'h2

// Core control: priority level most significant bit
`define TSP_CC_PRIO_MSB     3

// Status word: priority level low bits
`define TSP_SW_PRIO_HI      7
`define TSP_SW_PRIO_LO      5

// Trap status and control fields
`define TSP_TS_NEST_DIS     15
`define TSP_TS_OVA_FLAG     14
`define TSP_TS_OVB_FLAG     13
`define TSP_TS_COVA_FLAG    12
`define TSP_TS_COVB_FLAG    11
`define TSP_TS_OVA_EN       10
`define TSP_TS_OVB_EN       9
`define TSP_TS_COV_EN       8
`define TSP_TS_SHIFT_FLAG   7
`define TSP_TS_DIV0_FLAG    6
`define TSP_TS_DMA_FLAG     5
`define TSP_TS_MATH_FLAG    4
`define TSP_TS_ADDR_FLAG    3
`define TSP_TS_STACK_FLAG   2
`define TSP_TS_OSC_FLAG     1

// Bit 0 of trap status is unimplemented and reads zero
`define TSP_TS_IMPL_MASK    16'hfffe

// Reset values
`define TSP_TS_RESET        16'h0000
`define TSP_PRIO_LOW_RESET  3'h0
`define TSP_PRIO_MSB_RESET  1'b0
`define TSP_ZERO_WORD       16'h0000

// Priority levels
`define TSP_PRIO_MAX_LOW    3'h7
`define TSP_PRIO_THRESH     4'h7

// Trap request vector lanes
`define TSP_REQ_W           5
`define TSP_REQ_DMA         0
`define TSP_REQ_MATH        1
`define TSP_REQ_STACK       2
`define TSP_REQ_ADDR        3
`define TSP_REQ_OSC         4

`endif

// file: core/tsp_pkg.sv
// Purpose: Types shared by the trap unit files
// Assumes: tsp_defines.svh gives the register and request widths
// Notes:   Trap codes match the trap vector numbers
`include "tsp_defines.svh"

package tsp_pkg;

  // Trap vector numbers, zero when nothing is raised
  typedef enum logic [2:0] {
    TSP_VEC_NONE  = 3'b000,
    TSP_VEC_OSC   = 3'b001,
    TSP_VEC_ADDR  = 3'b010,
    TSP_VEC_STACK = 3'b011,
    TSP_VEC_MATH  = 3'b100,
    TSP_VEC_DMA   = 3'b101
  } tsp_trap_type;

  // State of the sticky flag bank
  typedef struct packed {
    logic [`TSP_REG_W-1:0] flags;
  } tsp_bank_state_type;

  // State of the top level
  typedef struct packed {
    logic [`TSP_REG_W-1:0] rdata;
    logic                  prio_msb;
    logic [2:0]            prio_low;
    logic                  in_service;
    logic [`TSP_REQ_W-1:0] trap_req;
    tsp_trap_type          trap_vec;
    logic                  irq_accept;
  } tsp_top_state_type;

endpackage : tsp_pkg

// file: core/tsp_flag_bank.sv
// Purpose: Bank of software-writable bits with hardware set inputs
// Assumes: Set inputs are one-cycle pulses or levels in the sys_clk domain
// Notes:   A set in the cycle of a software write wins over the written zero
`timescale 1ns/1ns
`include "tsp_defines.svh"

module tsp_flag_bank #(
  parameter int                    WIDTH     = `TSP_REG_W,
  parameter logic [`TSP_REG_W-1:0] IMPL_MASK = `TSP_TS_IMPL_MASK,
  parameter logic [`TSP_REG_W-1:0] RESET_VAL = `TSP_TS_RESET
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_value,
  input  wire logic [WIDTH-1:0] set_bits,
  output logic      [WIDTH-1:0] flags
);
  import tsp_pkg::*;

  tsp_bank_state_type    st_q;
  tsp_bank_state_type    st_d;
  logic [WIDTH-1:0]      nxt;

  // Per bit: written value or held value, then hardware set on top
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign nxt[i] = IMPL_MASK[i] &
                      (set_bits[i] | (wr_en ? wr_value[i] : st_q.flags[i]));
    end
  endgenerate

  always_comb begin
    st_d       = st_q;
    st_d.flags = nxt;
  end

  // Synchronous reset to the documented clear state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q.flags <= RESET_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

endmodule : tsp_flag_bank

// file: core/tsp_trap_unit.sv
// Purpose: Trap cause latching, trap enables, nesting control and CPU priority level
// Assumes: Trap event inputs are synchronous pulses from the core datapath
// Notes:   Three registers on a plain port; read data stand one cycle after the strobe
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "tsp_defines.svh"

module tsp_trap_unit (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // Register port
  input  wire logic [`TSP_ADDR_W-1:0] reg_addr,
  input  wire logic [`TSP_REG_W-1:0]  reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`TSP_REG_W-1:0]  reg_rdata,
  // Trap events from the datapath
  input  wire logic                   acc_a_overflow,
  input  wire logic                   acc_b_overflow,
  input  wire logic                   acc_a_catastrophic,
  input  wire logic                   acc_b_catastrophic,
  input  wire logic                   bad_shift,
  input  wire logic                   divide_zero,
  input  wire logic                   dma_fault,
  input  wire logic                   address_fault,
  input  wire logic                   stack_fault,
  input  wire logic                   oscillator_fault,
  // Level changes made by the core sequencer
  input  wire logic                   trap_enter,
  input  wire logic [2:0]             trap_level,
  input  wire logic                   irq_enter,
  input  wire logic [2:0]             irq_level,
  input  wire logic                   level_restore,
  input  wire logic [3:0]             restore_level,
  // Pending user interrupt offered by the interrupt controller
  input  wire logic                   irq_pending,
  input  wire logic [2:0]             irq_pend_level,
  // Results
  output tsp_pkg::tsp_trap_type       trap_vector,
  output logic      [`TSP_REQ_W-1:0]  trap_request,
  output logic      [3:0]             priority_level,
  output logic                        priority_level_msb,
  output logic                        nesting_disable,
  output logic                        irq_accept
);
  import tsp_pkg::*;

  tsp_top_state_type     st_q;
  tsp_top_state_type     st_d;
  logic [`TSP_REG_W-1:0] ts_flags;
  logic [`TSP_REG_W-1:0] ts_set;
  logic                  ts_wr;
  logic                  ova_trap;
  logic                  ovb_trap;
  logic                  cova_trap;
  logic                  covb_trap;
  logic                  math_trap;
  logic [`TSP_REQ_W-1:0] req_now;
  logic [3:0]            level_now;

  // Address decode, shared by the read and write paths
  function automatic logic tsp_hit(input logic [`TSP_ADDR_W-1:0] a,
                                   input logic [`TSP_ADDR_W-1:0] ofs);
    tsp_hit = (a == ofs);
  endfunction : tsp_hit

  // Highest-ranked trap of one cycle; oscillator failure outranks the rest
  function automatic tsp_trap_type tsp_encode(input logic [`TSP_REQ_W-1:0] r);
    if (r[`TSP_REQ_OSC]) begin
      tsp_encode = TSP_VEC_OSC;
    end else if (r[`TSP_REQ_ADDR]) begin
      tsp_encode = TSP_VEC_ADDR;
    end else if (r[`TSP_REQ_STACK]) begin
      tsp_encode = TSP_VEC_STACK;
    end else if (r[`TSP_REQ_MATH]) begin
      tsp_encode = TSP_VEC_MATH;
    end else if (r[`TSP_REQ_DMA]) begin
      tsp_encode = TSP_VEC_DMA;
    end else begin
      tsp_encode = TSP_VEC_NONE;
    end
  endfunction : tsp_encode

  // Accumulator events only become traps when their enable is set
  assign ova_trap  = acc_a_overflow & ts_flags[`TSP_TS_OVA_EN];
  assign ovb_trap  = acc_b_overflow & ts_flags[`TSP_TS_OVB_EN];
  assign cova_trap = acc_a_catastrophic & ts_flags[`TSP_TS_COV_EN];
  assign covb_trap = acc_b_catastrophic & ts_flags[`TSP_TS_COV_EN];

  // Every enabled accumulator trap and every arithmetic fault is a math trap
  assign math_trap = ova_trap | ovb_trap | cova_trap | covb_trap |
                     bad_shift | divide_zero;

  // Trap requests raised by this cycle's events
  always_comb begin
    req_now                 = '0;
    req_now[`TSP_REQ_DMA]   = dma_fault;
    req_now[`TSP_REQ_MATH]  = math_trap;
    req_now[`TSP_REQ_STACK] = stack_fault;
    req_now[`TSP_REQ_ADDR]  = address_fault;
    req_now[`TSP_REQ_OSC]   = oscillator_fault;
  end

  // Cause bits to set in the trap status register
  always_comb begin
    ts_set                      = '0;
    ts_set[`TSP_TS_OVA_FLAG]    = ova_trap;
    ts_set[`TSP_TS_OVB_FLAG]    = ovb_trap;
    ts_set[`TSP_TS_COVA_FLAG]   = cova_trap;
    ts_set[`TSP_TS_COVB_FLAG]   = covb_trap;
    ts_set[`TSP_TS_SHIFT_FLAG]  = bad_shift;
    ts_set[`TSP_TS_DIV0_FLAG]   = divide_zero;
    ts_set[`TSP_TS_DMA_FLAG]    = dma_fault;
    ts_set[`TSP_TS_MATH_FLAG]   = math_trap;
    ts_set[`TSP_TS_ADDR_FLAG]   = address_fault;
    ts_set[`TSP_TS_STACK_FLAG]  = stack_fault;
    ts_set[`TSP_TS_OSC_FLAG]    = oscillator_fault;
  end

  // Software write of the whole trap status word; reads never touch it
  assign ts_wr = reg_wr & tsp_hit(reg_addr, `TSP_OFS_TRAP_STAT);

  // Sticky flags, enables and nesting disable; a set beats a same-cycle clear
  tsp_flag_bank #(
    .WIDTH     (`TSP_REG_W),
    .IMPL_MASK (`TSP_TS_IMPL_MASK),
    .RESET_VAL (`TSP_TS_RESET)
  ) u_flags (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wr_en    (ts_wr),
    .wr_value (reg_wdata),
    .set_bits (ts_set),
    .flags    (ts_flags)
  );

  // Current four-bit level as held now
  assign level_now = {st_q.prio_msb, st_q.prio_low};

  // Next state of priority level, requests and read data
  always_comb begin
    st_d = st_q;

    // Read data stand for the one cycle after the strobe, zero otherwise
    st_d.rdata = `TSP_ZERO_WORD;
    if (reg_rd) begin
      if (tsp_hit(reg_addr, `TSP_OFS_CORE_CTRL)) begin
        // Only the level MSB is held here; it reads 1 above level 7
        st_d.rdata[`TSP_CC_PRIO_MSB] = (level_now > `TSP_PRIO_THRESH);
      end else if (tsp_hit(reg_addr, `TSP_OFS_TRAP_STAT)) begin
        st_d.rdata = ts_flags;
      end else if (tsp_hit(reg_addr, `TSP_OFS_STATUS_WORD)) begin
        st_d.rdata[`TSP_SW_PRIO_HI:`TSP_SW_PRIO_LO] = st_q.prio_low;
      end else begin
        st_d.rdata = `TSP_ZERO_WORD;
      end
    end

    // Software writes to the status-word level bits are ignored while nesting is disabled
    if (reg_wr && tsp_hit(reg_addr, `TSP_OFS_STATUS_WORD) &&
        !ts_flags[`TSP_TS_NEST_DIS]) begin
      st_d.prio_low = reg_wdata[`TSP_SW_PRIO_HI:`TSP_SW_PRIO_LO];
    end

    // The MSB can only be cleared by software, never set
    if (reg_wr && tsp_hit(reg_addr, `TSP_OFS_CORE_CTRL) &&
        !reg_wdata[`TSP_CC_PRIO_MSB]) begin
      st_d.prio_msb = 1'b0;
    end

    // Core sequencer changes rank above software writes in the same cycle
    if (level_restore) begin
      st_d.prio_msb   = restore_level[3];
      st_d.prio_low   = restore_level[2:0];
      st_d.in_service = 1'b0;
    end

    // Entering a user interrupt; with nesting off the level goes to 7
    if (irq_enter) begin
      st_d.in_service = 1'b1;
      if (ts_flags[`TSP_TS_NEST_DIS]) begin
        st_d.prio_low = `TSP_PRIO_MAX_LOW;
      end else begin
        st_d.prio_low = irq_level;
      end
    end

    // Entering a trap always lifts the level above 7, out of software reach
    if (trap_enter) begin
      st_d.prio_msb = 1'b1;
      st_d.prio_low = trap_level;
    end

    // One-cycle trap requests and the winning vector
    st_d.trap_req = req_now;
    st_d.trap_vec = tsp_encode(req_now);

    // A pending user interrupt is taken only above the current level, and
    // never while another one runs with nesting disabled
    st_d.irq_accept = irq_pending &&
                      !st_q.prio_msb &&
                      (irq_pend_level > st_q.prio_low) &&
                      !(ts_flags[`TSP_TS_NEST_DIS] && st_q.in_service);
  end

  // Single register stage for all top-level state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q.rdata      <= `TSP_ZERO_WORD;
      st_q.prio_msb   <= `TSP_PRIO_MSB_RESET;
      st_q.prio_low   <= `TSP_PRIO_LOW_RESET;
      st_q.in_service <= 1'b0;
      st_q.trap_req   <= '0;
      st_q.trap_vec   <= TSP_VEC_NONE;
      st_q.irq_accept <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata          = st_q.rdata;
  assign trap_vector        = st_q.trap_vec;
  assign trap_request       = st_q.trap_req;
  assign priority_level     = level_now;
  assign priority_level_msb = st_q.prio_msb;
  assign nesting_disable    = ts_flags[`TSP_TS_NEST_DIS];
  assign irq_accept         = st_q.irq_accept;

endmodule : tsp_trap_unit

// file: tb/tsp_trap_unit_props.sv
// Purpose: Port-level checks of the trap unit
// Assumes: Read data follow the read strobe by one cycle
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
`include "tsp_defines.svh"

module tsp_trap_props (
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic [3:0]            reg_addr,
  input wire logic [15:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  divide_zero,
  input wire logic                  dma_fault,
  input wire logic                  oscillator_fault,
  input wire logic                  trap_enter,
  input wire logic [2:0]            trap_level,
  input wire logic                  irq_enter,
  input wire logic                  level_restore,
  input wire tsp_pkg::tsp_trap_type trap_vector,
  input wire logic [4:0]            trap_request,
  input wire logic [3:0]            priority_level,
  input wire logic                  priority_level_msb,
  input wire logic                  nesting_disable
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_ctrl_read: assert property (reg_rd && reg_addr == `TSP_OFS_CORE_CTRL
    |=> reg_rdata == {12'h000, $past(priority_level_msb), 3'h0})
    else $error("core control read wrong");
  a_word_read: assert property (reg_rd && reg_addr == `TSP_OFS_STATUS_WORD
    |=> reg_rdata == {8'h00, $past(priority_level[2:0]), 5'h00})
    else $error("status word read wrong");
  a_trap_level: assert property (trap_enter && !irq_enter && !level_restore
    |=> priority_level == {1'b1, $past(trap_level)})
    else $error("trap entry level wrong");
  a_math_req: assert property (divide_zero |=> trap_request[`TSP_REQ_MATH])
    else $error("math request missing");
  a_dma_req: assert property (dma_fault |=> trap_request[`TSP_REQ_DMA])
    else $error("dma request missing");
  a_osc_first: assert property (oscillator_fault
    |=> trap_vector == tsp_pkg::TSP_VEC_OSC)
    else $error("oscillator vector wrong");
  a_nest_write: assert property (reg_wr && reg_addr == `TSP_OFS_TRAP_STAT
    |=> nesting_disable == $past(reg_wdata[15]))
    else $error("nesting bit not written");
  a_msb_locked: assert property (reg_wr && reg_addr == `TSP_OFS_CORE_CTRL
    && !priority_level_msb && !trap_enter && !level_restore |=> !priority_level_msb)
    else $error("software set priority msb");
endmodule : tsp_trap_props

bind tsp_trap_unit tsp_trap_props u_props (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .divide_zero, .dma_fault, .oscillator_fault, .trap_enter,
  .trap_level, .irq_enter, .level_restore, .trap_vector, .trap_request, .priority_level,
  .priority_level_msb, .nesting_disable);

// file: tb/tsp_core_model.sv
// Purpose: Datapath stand-in that reports trap events
// Assumes: fire bits are set by the bench after a rising edge
// Notes:   Events leave on an edge, so a held fire bit becomes a level event
`timescale 1ns/1ns

module tsp_core_model (
  input  wire logic       sys_clk,
  input  wire logic [9:0] fire,
  output logic      [9:0] events
);
  // Registered like real datapath status, idle low between events
  always_ff @(posedge sys_clk) begin
    events <= fire;
  end
endmodule : tsp_core_model

// file: tb/tsp_trap_unit_bench.sv
// Purpose: Register and event tests of the trap unit
// Assumes: Offsets and lanes from tsp_defines.svh
// Notes:   Every input is driven right after a rising edge
`timescale 1ns/1ns
`include "tsp_defines.svh"

module tsp_trap_unit_bench;
  logic                  sys_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [3:0]            reg_addr = 4'h0;
  logic [15:0]           reg_wdata = 16'h0000;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [15:0]           reg_rdata;
  logic [15:0]           got;
  logic [9:0]            fire = 10'h000;
  logic [9:0]            ev;
  logic                  trap_enter = 1'b0;
  logic                  irq_enter = 1'b0;
  logic                  level_restore = 1'b0;
  logic                  irq_pending = 1'b0;
  logic [2:0]            lvl3 = 3'h0;
  logic [3:0]            lvl4 = 4'h0;
  tsp_pkg::tsp_trap_type trap_vector;
  logic [4:0]            trap_request;
  logic [3:0]            priority_level;
  logic                  priority_level_msb;
  logic                  nesting_disable;
  logic                  irq_accept;
  int                    fail_count = 0;
  int                    tests_run = 0;
  // Flags expected per fire lane: ova ovb cova covb shift div0 dma addr stack osc
  logic [15:0] exp_bits [0:9] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
                                  16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

  tsp_trap_unit uut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .acc_a_overflow(ev[0]), .acc_b_overflow(ev[1]),
    .acc_a_catastrophic(ev[2]), .acc_b_catastrophic(ev[3]), .bad_shift(ev[4]),
    .divide_zero(ev[5]), .dma_fault(ev[6]), .address_fault(ev[7]), .stack_fault(ev[8]),
    .oscillator_fault(ev[9]), .trap_enter, .trap_level(lvl3), .irq_enter,
    .irq_level(lvl3), .level_restore, .restore_level(lvl4), .irq_pending,
    .irq_pend_level(lvl3), .trap_vector, .trap_request, .priority_level,
    .priority_level_msb, .nesting_disable, .irq_accept);

  tsp_core_model u_core (.sys_clk, .fire, .events(ev));

  // Free-running core clock
  always #50 sys_clk = ~sys_clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Data are taken just after the edge that follows the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk(got, e);
  endtask : rchk

  task automatic fire_ev(input int i);
    @(posedge sys_clk);
    fire <= 10'h001 << i;
    @(posedge sys_clk);
    fire <= 10'h000;
    repeat (2) @(posedge sys_clk);
  endtask : fire_ev

  // op bits: restore, irq entry, trap entry
  task automatic lv(input logic [2:0] op, input logic [2:0] l3, input logic [3:0] l4);
    @(posedge sys_clk);
    {level_restore, irq_enter, trap_enter} <= op;
    lvl3 <= l3;
    lvl4 <= l4;
    @(posedge sys_clk);
    {level_restore, irq_enter, trap_enter} <= 3'b000;
    #1;
  endtask : lv

  task automatic pend(input logic [2:0] l, input logic e);
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    lvl3        <= l;
    @(posedge sys_clk);
    irq_pending <= 1'b0;
    #1 chk({15'h0000, irq_accept}, {15'h0000, e});
  endtask : pend

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(`TSP_OFS_CORE_CTRL, 16'h0000);
    rchk(`TSP_OFS_TRAP_STAT, `TSP_TS_RESET);
    rchk(`TSP_OFS_STATUS_WORD, 16'h0000);
    wr(4'h5, 16'hffff);
    rchk(4'h5, 16'h0000);
    wr(`TSP_OFS_TRAP_STAT, 16'h0700);
    for (int i = 0; i < 10; i++) begin
      fire_ev(i);
      rchk(`TSP_OFS_TRAP_STAT, 16'h0700 | exp_bits[i]);
      rchk(`TSP_OFS_TRAP_STAT, 16'h0700 | exp_bits[i]);
      wr(`TSP_OFS_TRAP_STAT, 16'h0700);
      rchk(`TSP_OFS_TRAP_STAT, 16'h0700);
    end
    wr(`TSP_OFS_TRAP_STAT, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      fire_ev(i);
    end
    rchk(`TSP_OFS_TRAP_STAT, 16'h0000);
    wr(`TSP_OFS_STATUS_WORD, 16'h00a0);
    rchk(`TSP_OFS_STATUS_WORD, 16'h00a0);
    lv(3'b001, 3'h3, 4'h0);
    chk({12'h000, priority_level}, 16'h000b);
    rchk(`TSP_OFS_CORE_CTRL, 16'h0008);
    lv(3'b100, 3'h0, 4'h7);
    rchk(`TSP_OFS_CORE_CTRL, 16'h0000);
    wr(`TSP_OFS_CORE_CTRL, 16'h0008);
    rchk(`TSP_OFS_CORE_CTRL, 16'h0000);
    lv(3'b100, 3'h0, 4'h8);
    rchk(`TSP_OFS_CORE_CTRL, 16'h0008);
    wr(`TSP_OFS_CORE_CTRL, 16'h0000);
    wr(`TSP_OFS_TRAP_STAT, 16'h8000);
    chk({15'h0000, nesting_disable}, 16'h0001);
    wr(`TSP_OFS_STATUS_WORD, 16'h0020);
    rchk(`TSP_OFS_STATUS_WORD, 16'h0000);
    lv(3'b010, 3'h2, 4'h0);
    chk({12'h000, priority_level}, 16'h0007);
    wr(`TSP_OFS_TRAP_STAT, 16'h0000);
    lv(3'b010, 3'h2, 4'h0);
    chk({12'h000, priority_level}, 16'h0002);
    pend(3'h3, 1'b1);
    pend(3'h2, 1'b0);
    wr(`TSP_OFS_STATUS_WORD, 16'h0020);
    rchk(`TSP_OFS_STATUS_WORD, 16'h0020);
    // Reset in mid-run must drop enables, nesting and level together
    wr(`TSP_OFS_TRAP_STAT, 16'h8700);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(`TSP_OFS_TRAP_STAT, `TSP_TS_RESET);
    chk({15'h0000, nesting_disable}, 16'h0000);
    chk({12'h000, priority_level}, 16'h0000);
    final_report();
  end
endmodule : tsp_trap_unit_bench
